// ===== core/fan_regs_defs.svh
// register numbers, codes, limits and reset values of the holding-register bank
`ifndef FAN_REGS_DEFS_SVH
`define FAN_REGS_DEFS_SVH

`define FC_READ_HOLDING     8'h03
`define FC_READ_INPUT       8'h04
`define FC_WRITE_SINGLE     8'h06
`define EXC_NONE            8'h00
`define EXC_BAD_FUNCTION    8'h01
`define EXC_BAD_ADDRESS     8'h02
`define EXC_BAD_VALUE       8'h03

`define OFS_FAULT_RESET     16'h0000
`define OFS_SPEED_FLOOR     16'h0001
`define OFS_SPEED_CEILING   16'h0002
`define OFS_CURRENT_LIMIT   16'h0007
`define OFS_LOWER_THRESH    16'h0010
`define OFS_STORED_SPEED    16'h0015
`define OFS_POLARITY        16'h001f
`define OFS_SKIP_LOW        16'h0020
`define OFS_SKIP_HIGH       16'h0021
`define OFS_MODE_SELECT     16'h0022
`define OFS_COAST_SPEED     16'h0023
`define OFS_POWER_LIMIT     16'h0024
`define OFS_NODE_ADDRESS    16'h002d
`define OFS_DOUT_FUNCTION   16'h002e
`define OFS_LINE_RATE       16'h002f
`define OFS_FRAME_FORMAT    16'h0030
`define OFS_EXT_REFERENCE   16'h0032
`define OFS_PROP_GAIN       16'h0033
`define OFS_INT_GAIN        16'h0034
`define OFS_DERIV_GAIN      16'h0035
`define OFS_LOOP_PERIOD     16'h0036
`define OFS_UPPER_THRESH    16'h0037
`define OFS_LINK_TIMEOUT    16'h0038
`define OFS_VOLATILE_SETPT  16'h0042

`define RST_FAULT_RESET     16'h0000
`define RST_STORED_SPEED    16'h0000
`define RST_POLARITY        16'h0000
`define RST_SKIP_LOW        16'h4e20
`define RST_SKIP_HIGH       16'h4e20
`define RST_MODE_SELECT     16'h0001
`define RST_COAST_SPEED     16'h4e20
`define RST_NODE_ADDRESS    16'h0001
`define RST_DOUT_FUNCTION   16'h0000
`define RST_LINE_RATE       16'h0060
`define RST_FRAME_FORMAT    16'h0000

`define SPEED_LIMIT_RPM     16'h4e20
`define MODE_LAST           16'h000c
`define MODE_FIXED_SPEED    16'h0002
`define MODE_FIXED_LOOP     16'h000c
`define DOUT_RANGE_CODE     16'h0003
`define DOUT_LAST           16'h0003
`define NODE_ADDR_LAST      16'h00f7
`define FRAME_LAST          16'h0002
`define RATE_9K6            16'h0060
`define RATE_19K2           16'h00c0
`define EXT_REF_LAST        16'h0064
`define GAIN_LAST           16'h7fff
`define POWER_FIRST         16'h000a

`endif

// ===== core/fan_regs_pkg.sv
// types shared by the holding-register bank and its helpers
package fan_regs_pkg;

   typedef struct packed {
      logic [7:0]  func;
      logic [15:0] addr;
      logic [15:0] data;
   } mb_req_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  func;
      logic [7:0]  exc;
      logic [15:0] data;
   } mb_rsp_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic [15:0] data;
   } nv_word_t;

   typedef enum logic [2:0] {
      FAM_SPEED     = 3'b000,
      FAM_SLAVE     = 3'b001,
      FAM_AIRFLOW   = 3'b010,
      FAM_EMULATION = 3'b011,
      FAM_LOOP      = 3'b100
   } drive_family_t;

   typedef enum logic [1:0] {
      SRC_ANALOG    = 2'b00,
      SRC_TEMPORARY = 2'b01,
      SRC_STORED    = 2'b10,
      SRC_MASTER    = 2'b11
   } ref_source_t;

   typedef enum logic [1:0] {
      ST_IDLE       = 2'b00,
      ST_INPUT_WAIT = 2'b01
   } bank_state_t;

   typedef struct packed {
      drive_family_t family;
      ref_source_t   source;
      logic [15:0]   reference;
      logic          feedback_invert;
      logic [15:0]   speed_floor;
      logic [15:0]   speed_ceiling;
      logic [15:0]   current_limit;
      logic [15:0]   threshold_low;
      logic [15:0]   threshold_high;
      logic [15:0]   skip_low;
      logic [15:0]   skip_high;
      logic [15:0]   coast_speed;
      logic [15:0]   power_limit;
   } drive_cfg_t;

endpackage

// ===== core/fan_mode_decode.sv
// operating-mode code to control family and reference source
`timescale 1ns/1ns
module fan_mode_decode
   import fan_regs_pkg::*;
(
   input  wire logic [15:0]   mode,
   output drive_family_t      family,
   output ref_source_t        source
);

   always_comb begin
      family = FAM_SPEED;
      source = SRC_ANALOG;
      case (mode)
         16'h0000: begin family = FAM_SPEED;     source = SRC_TEMPORARY; end
         16'h0001: begin family = FAM_SPEED;     source = SRC_ANALOG;    end
         16'h0002: begin family = FAM_SPEED;     source = SRC_STORED;    end
         16'h0003: begin family = FAM_SLAVE;     source = SRC_MASTER;    end
         16'h0004: begin family = FAM_AIRFLOW;   source = SRC_ANALOG;    end
         16'h0005: begin family = FAM_AIRFLOW;   source = SRC_TEMPORARY; end
         16'h0006: begin family = FAM_AIRFLOW;   source = SRC_STORED;    end
         16'h0007: begin family = FAM_EMULATION; source = SRC_ANALOG;    end
         16'h0008: begin family = FAM_EMULATION; source = SRC_TEMPORARY; end
         16'h0009: begin family = FAM_EMULATION; source = SRC_STORED;    end
         16'h000a: begin family = FAM_LOOP;      source = SRC_ANALOG;    end
         16'h000b: begin family = FAM_LOOP;      source = SRC_TEMPORARY; end
         16'h000c: begin family = FAM_LOOP;      source = SRC_STORED;    end
         default: begin family = FAM_SPEED;      source = SRC_ANALOG;    end
      endcase
   end

endmodule

// ===== core/fan_write_bounds.sv
// which register numbers exist, and whether a written value lies in its bounds
`timescale 1ns/1ns
`include "fan_regs_defs.svh"
module fan_write_bounds
   import fan_regs_pkg::*;
#(
   parameter logic [15:0] MIN_SPEED_DEFAULT = 16'h012c,
   parameter logic [15:0] MAX_SPEED_DEFAULT = 16'h0bb8,
   parameter logic [15:0] CURRENT_DEFAULT   = 16'h1964,
   parameter logic [15:0] POWER_DEFAULT     = 16'h0a5a
)
(
   input  wire logic [15:0]   addr,
   input  wire logic [15:0]   value,
   input  wire logic [15:0]   floor_now,
   input  wire logic [15:0]   ceiling_now,
   input  wire logic [15:0]   skip_low_now,
   input  wire logic [15:0]   skip_high_now,
   input  wire logic [15:0]   low_thresh_now,
   input  wire logic [15:0]   dout_now,
   output logic               known,
   output logic               in_bounds
);

   always_comb begin
      known     = 1'b1;
      in_bounds = 1'b1;
      case (addr)
         `OFS_FAULT_RESET, `OFS_POLARITY: in_bounds = (value <= 16'h0001);
         `OFS_SPEED_FLOOR:   in_bounds = (value >= MIN_SPEED_DEFAULT) && (value <= ceiling_now);
         `OFS_SPEED_CEILING: in_bounds = (value >= floor_now) && (value <= MAX_SPEED_DEFAULT);
         `OFS_CURRENT_LIMIT: in_bounds = (value >= 16'h0001) && (value <= CURRENT_DEFAULT);
         `OFS_LOWER_THRESH:  in_bounds = (value <= ceiling_now);
         `OFS_STORED_SPEED:  in_bounds = (value >= floor_now) && (value <= ceiling_now);
         `OFS_SKIP_LOW:      in_bounds = (value <= skip_high_now);
         `OFS_SKIP_HIGH:     in_bounds = (value >= skip_low_now) && (value <= `SPEED_LIMIT_RPM);
         `OFS_MODE_SELECT:   in_bounds = (value <= `MODE_LAST);
         `OFS_COAST_SPEED:   in_bounds = (value <= `SPEED_LIMIT_RPM);
         `OFS_POWER_LIMIT:   in_bounds = (value >= `POWER_FIRST) && (value <= POWER_DEFAULT);
         `OFS_NODE_ADDRESS:  in_bounds = (value >= 16'h0001) && (value <= `NODE_ADDR_LAST);
         `OFS_DOUT_FUNCTION: in_bounds = (value <= `DOUT_LAST);
         `OFS_LINE_RATE:     in_bounds = (value == `RATE_9K6) || (value == `RATE_19K2);
         `OFS_FRAME_FORMAT:  in_bounds = (value <= `FRAME_LAST);
         `OFS_EXT_REFERENCE: in_bounds = (value <= `EXT_REF_LAST);
         `OFS_PROP_GAIN, `OFS_INT_GAIN, `OFS_DERIV_GAIN, `OFS_LOOP_PERIOD,
         `OFS_LINK_TIMEOUT:  in_bounds = (value <= `GAIN_LAST);
         // in range-indication mode the upper threshold sits at or above the lower one
         `OFS_UPPER_THRESH:  in_bounds = (value <= ceiling_now) &&
                                ((dout_now != `DOUT_RANGE_CODE) || (value >= low_thresh_now));
         default: begin
            known     = 1'b0;
            in_bounds = 1'b0;
         end
      endcase
   end

endmodule

// ===== core/fan_holding_registers.sv
// holding-register bank of the fan drive, served one register request at a time
`timescale 1ns/1ns
`include "fan_regs_defs.svh"
module fan_holding_registers
   import fan_regs_pkg::*;
#(
   parameter int          HOLD_WORDS        = 57,
   parameter logic [15:0] MIN_SPEED_DEFAULT = 16'h012c,
   parameter logic [15:0] MAX_SPEED_DEFAULT = 16'h0bb8,
   parameter logic [15:0] CURRENT_DEFAULT   = 16'h1964,
   parameter logic [15:0] POWER_DEFAULT     = 16'h0a5a,
   parameter logic [15:0] LOW_THRESH_DEFAULT = 16'h0000
)
(
   input  wire logic          clock,
   input  wire logic          nrst,
   input  wire logic          cold_start,
   input  wire logic          req_valid,
   input  wire mb_req_t       req,
   output logic               req_ready,
   output mb_rsp_t            rsp,
   output logic               input_read,
   output logic [15:0]        input_addr,
   input  wire logic [15:0]   input_data,
   input  wire logic          motor_running,
   input  wire nv_word_t      restore,
   output nv_word_t           nv_write,
   output logic               fault_clear,
   input  wire logic [15:0]   analog_level,
   output drive_cfg_t         cfg
);

   typedef struct packed {
      bank_state_t                     fsm;
      logic [HOLD_WORDS-1:0][15:0]     hold;
      logic [15:0]                     temp_setpoint;
      logic                            req_ready;
      mb_rsp_t                         rsp;
      logic                            input_read;
      logic [15:0]                     input_addr;
      nv_word_t                        nv;
      logic                            fault_clear;
      drive_cfg_t                      cfg;
   } bank_t;

   bank_t         cur;
   bank_t         next_cur;
   logic          req_known;
   logic          req_ok;
   logic          rst_known;
   drive_family_t mode_family;
   ref_source_t   mode_source;
   logic [5:0]    req_index;
   logic [5:0]    rst_index;

   assign req_index = req.addr[5:0];
   assign rst_index = restore.addr[5:0];

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   fan_write_bounds #(
      .MIN_SPEED_DEFAULT (MIN_SPEED_DEFAULT),
      .MAX_SPEED_DEFAULT (MAX_SPEED_DEFAULT),
      .CURRENT_DEFAULT   (CURRENT_DEFAULT),
      .POWER_DEFAULT     (POWER_DEFAULT)
   ) u_req_bounds (
      .addr           (req.addr),
      .value          (req.data),
      .floor_now      (cur.hold[`OFS_SPEED_FLOOR]),
      .ceiling_now    (cur.hold[`OFS_SPEED_CEILING]),
      .skip_low_now   (cur.hold[`OFS_SKIP_LOW]),
      .skip_high_now  (cur.hold[`OFS_SKIP_HIGH]),
      .low_thresh_now (cur.hold[`OFS_LOWER_THRESH]),
      .dout_now       (cur.hold[`OFS_DOUT_FUNCTION]),
      .known          (req_known),
      .in_bounds      (req_ok)
   );

   // the restore port only needs to know whether the number exists
   fan_write_bounds #(
      .MIN_SPEED_DEFAULT (MIN_SPEED_DEFAULT),
      .MAX_SPEED_DEFAULT (MAX_SPEED_DEFAULT),
      .CURRENT_DEFAULT   (CURRENT_DEFAULT),
      .POWER_DEFAULT     (POWER_DEFAULT)
   ) u_restore_map (
      .addr           (restore.addr),
      .value          (restore.data),
      .floor_now      (cur.hold[`OFS_SPEED_FLOOR]),
      .ceiling_now    (cur.hold[`OFS_SPEED_CEILING]),
      .skip_low_now   (cur.hold[`OFS_SKIP_LOW]),
      .skip_high_now  (cur.hold[`OFS_SKIP_HIGH]),
      .low_thresh_now (cur.hold[`OFS_LOWER_THRESH]),
      .dout_now       (cur.hold[`OFS_DOUT_FUNCTION]),
      .known          (rst_known),
      .in_bounds      ()
   );

   fan_mode_decode u_mode (
      .mode   (cur.hold[`OFS_MODE_SELECT]),
      .family (mode_family),
      .source (mode_source)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state
   // later assignments win: the reset command falls back to zero first, so a
   // fresh write of one right after still lands; a request write beats a
   // restore word aimed at the same register; reset overrides everything

   always_comb begin
      next_cur = cur;
      next_cur.rsp.valid   = 1'b0;
      next_cur.input_read  = 1'b0;
      next_cur.nv.valid    = 1'b0;
      next_cur.fault_clear = 1'b0;

      // the reset command holds one for a single cycle only
      if (cur.hold[`OFS_FAULT_RESET] != `RST_FAULT_RESET) begin
         next_cur.hold[`OFS_FAULT_RESET] = `RST_FAULT_RESET;
      end

      // power-up copy from nonvolatile storage, taken without bounds checks
      if (restore.valid && rst_known) begin
         next_cur.hold[rst_index] = restore.data;
      end

      case (cur.fsm)
         ST_IDLE: begin
            if (req_valid) begin
               next_cur.rsp.valid = 1'b1;
               next_cur.rsp.func  = req.func;
               next_cur.rsp.exc   = `EXC_NONE;
               next_cur.rsp.data  = req.data;
               case (req.func)
                  `FC_READ_HOLDING: begin
                     // register 66 is not backed by readable storage
                     if (req_known) begin
                        next_cur.rsp.data = cur.hold[req_index];
                     end else begin
                        next_cur.rsp.exc  = `EXC_BAD_ADDRESS;
                        next_cur.rsp.data = 16'h0000;
                     end
                  end
                  `FC_READ_INPUT: begin
                     next_cur.rsp.valid  = 1'b0;
                     next_cur.input_read = 1'b1;
                     next_cur.input_addr = req.addr;
                     next_cur.req_ready  = 1'b0;
                     next_cur.fsm        = ST_INPUT_WAIT;
                  end
                  `FC_WRITE_SINGLE: begin
                     if (req.addr == `OFS_VOLATILE_SETPT) begin
                        next_cur.temp_setpoint = req.data;
                     end else if (!req_known) begin
                        next_cur.rsp.exc = `EXC_BAD_ADDRESS;
                     end else if (!req_ok) begin
                        next_cur.rsp.exc = `EXC_BAD_VALUE;
                     end else begin
                        next_cur.hold[req_index] = req.data;
                        if (req.addr == `OFS_FAULT_RESET) begin
                           next_cur.fault_clear = req.data[0];
                        end else if (!motor_running) begin
                           next_cur.nv.valid = 1'b1;
                           next_cur.nv.addr  = req.addr;
                           next_cur.nv.data  = req.data;
                        end
                     end
                  end
                  default: begin
                     next_cur.rsp.exc  = `EXC_BAD_FUNCTION;
                     next_cur.rsp.data = 16'h0000;
                  end
               endcase
            end
         end
         ST_INPUT_WAIT: begin
            next_cur.rsp.valid = 1'b1;
            next_cur.rsp.func  = `FC_READ_INPUT;
            next_cur.rsp.exc   = `EXC_NONE;
            next_cur.rsp.data  = input_data;
            next_cur.req_ready = 1'b1;
            next_cur.fsm       = ST_IDLE;
         end
         default: begin
            next_cur.fsm       = ST_IDLE;
            next_cur.req_ready = 1'b1;
         end
      endcase

      // configuration seen by the motor control
      next_cur.cfg.family          = mode_family;
      next_cur.cfg.source          = mode_source;
      next_cur.cfg.feedback_invert = cur.hold[`OFS_POLARITY][0];
      next_cur.cfg.speed_floor     = cur.hold[`OFS_SPEED_FLOOR];
      next_cur.cfg.speed_ceiling   = cur.hold[`OFS_SPEED_CEILING];
      next_cur.cfg.current_limit   = cur.hold[`OFS_CURRENT_LIMIT];
      next_cur.cfg.threshold_high  = cur.hold[`OFS_UPPER_THRESH];
      next_cur.cfg.skip_low        = cur.hold[`OFS_SKIP_LOW];
      next_cur.cfg.skip_high       = cur.hold[`OFS_SKIP_HIGH];
      next_cur.cfg.coast_speed     = cur.hold[`OFS_COAST_SPEED];
      next_cur.cfg.power_limit     = cur.hold[`OFS_POWER_LIMIT];
      if (cur.hold[`OFS_DOUT_FUNCTION] == `DOUT_RANGE_CODE) begin
         next_cur.cfg.threshold_low = cur.hold[`OFS_LOWER_THRESH];
      end else begin
         next_cur.cfg.threshold_low = 16'h0000;
      end
      case (mode_source)
         SRC_TEMPORARY: next_cur.cfg.reference = cur.temp_setpoint;
         SRC_STORED: begin
            // the stored references of modes 6 and 9 are not held in this bank
            if (cur.hold[`OFS_MODE_SELECT] == `MODE_FIXED_SPEED) begin
               next_cur.cfg.reference = cur.hold[`OFS_STORED_SPEED];
            end else if (cur.hold[`OFS_MODE_SELECT] == `MODE_FIXED_LOOP) begin
               next_cur.cfg.reference = cur.hold[`OFS_EXT_REFERENCE];
            end else begin
               next_cur.cfg.reference = 16'h0000;
            end
         end
         default: next_cur.cfg.reference = analog_level;
      endcase

      // synchronous reset: defaults, except a warm restart keeps register 66
      if (!nrst) begin
         next_cur = '0;
         next_cur.fsm                          = ST_IDLE;
         next_cur.req_ready                    = 1'b1;
         next_cur.temp_setpoint                = cold_start ? 16'h0000 : cur.temp_setpoint;
         next_cur.hold[`OFS_FAULT_RESET]       = `RST_FAULT_RESET;
         next_cur.hold[`OFS_SPEED_FLOOR]       = MIN_SPEED_DEFAULT;
         next_cur.hold[`OFS_SPEED_CEILING]     = MAX_SPEED_DEFAULT;
         next_cur.hold[`OFS_CURRENT_LIMIT]     = CURRENT_DEFAULT;
         next_cur.hold[`OFS_LOWER_THRESH]      = LOW_THRESH_DEFAULT;
         next_cur.hold[`OFS_STORED_SPEED]      = `RST_STORED_SPEED;
         next_cur.hold[`OFS_POLARITY]          = `RST_POLARITY;
         next_cur.hold[`OFS_SKIP_LOW]          = `RST_SKIP_LOW;
         next_cur.hold[`OFS_SKIP_HIGH]         = `RST_SKIP_HIGH;
         next_cur.hold[`OFS_MODE_SELECT]       = `RST_MODE_SELECT;
         next_cur.hold[`OFS_COAST_SPEED]       = `RST_COAST_SPEED;
         next_cur.hold[`OFS_POWER_LIMIT]       = POWER_DEFAULT;
         next_cur.hold[`OFS_NODE_ADDRESS]      = `RST_NODE_ADDRESS;
         next_cur.hold[`OFS_DOUT_FUNCTION]     = `RST_DOUT_FUNCTION;
         next_cur.hold[`OFS_LINE_RATE]         = `RST_LINE_RATE;
         next_cur.hold[`OFS_FRAME_FORMAT]      = `RST_FRAME_FORMAT;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register and outputs

   always_ff @(posedge clock) begin
      cur <= next_cur;
   end

   assign req_ready   = cur.req_ready;
   assign rsp         = cur.rsp;
   assign input_read  = cur.input_read;
   assign input_addr  = cur.input_addr;
   assign nv_write    = cur.nv;
   assign fault_clear = cur.fault_clear;
   assign cfg         = cur.cfg;

endmodule

// ===== verification/fan_regs_properties.sv
// assertions on the holding-register bank ports
`timescale 1ns/1ns
module fan_regs_properties
   import fan_regs_pkg::*;
(
   input wire logic     clock,
   input wire logic     nrst,
   input wire logic     req_valid,
   input wire mb_req_t  req,
   input wire logic     req_ready,
   input wire mb_rsp_t  rsp,
   input wire logic     input_read,
   input wire logic     motor_running,
   input wire nv_word_t nv_write,
   input wire logic     fault_clear
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   wire take = req_valid && req_ready;
   wire wr = take && req.func == 8'h06;
   sequence s_input_wait;
      input_read && !req_ready ##1 rsp.valid && req_ready;
   endsequence
   sequence s_clear_pulse;
      fault_clear ##1 !fault_clear;
   endsequence
   a_write_echo: assert property (wr |=> rsp.valid && rsp.data == $past(req.data))
      else $error("write answer wrong");
   a_read_answer: assert property (take && req.func == 8'h03 |=> rsp.valid && rsp.func == 8'h03)
      else $error("read answer missing");
   a_store_match: assert property (nv_write.valid |-> $past(wr)
      && nv_write.addr == $past(req.addr) && nv_write.data == $past(req.data))
      else $error("stored word does not match the write");
   a_input_read: assert property (take && req.func == 8'h04 |=> s_input_wait)
      else $error("input read sequence wrong");
   a_bad_function: assert property (take && !(req.func inside {8'h03, 8'h04, 8'h06})
      |=> rsp.valid && rsp.exc == 8'h01)
      else $error("bad function not refused");
   a_hidden_setpoint: assert property (take && req.func == 8'h03 && req.addr == 16'h0042
      |=> rsp.exc == 8'h02)
      else $error("setpoint readable");
   a_fault_pulse: assert property (wr && req.addr == 16'h0 && req.data == 16'h1
      |=> s_clear_pulse)
      else $error("fault clear pulse wrong");
   a_run_no_store: assert property (nv_write.valid |-> !$past(motor_running))
      else $error("stored while running");
   a_volatile_no_store: assert property (nv_write.valid |-> nv_write.addr != 16'h0042)
      else $error("setpoint stored");
   a_mode_refused: assert property (wr && req.addr == 16'h0022 && req.data > 16'h000c
      |=> rsp.exc == 8'h03 && !nv_write.valid)
      else $error("bad mode taken");
endmodule
bind fan_holding_registers fan_regs_properties u_props (.clock(clock), .nrst(nrst),
   .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp(rsp),
   .input_read(input_read), .motor_running(motor_running), .nv_write(nv_write),
   .fault_clear(fault_clear));

// ===== verification/fan_input_file.sv
// input-register file answering the bank's input reads
`timescale 1ns/1ns
module fan_input_file
(
   input  wire logic        clock,
   input  wire logic        input_read,
   input  wire logic [15:0] input_addr,
   output logic [15:0]      input_data
);
   logic [15:0] churn = 16'h00ff;
   // outside a read the line changes every cycle
   always @(posedge clock) churn <= ~churn;
   assign input_data = input_read ? input_addr ^ 16'h5a00 : churn;
endmodule

// ===== verification/fan_holding_registers_tb.sv
// self-checking bench of the holding-register bank
`timescale 1ns/1ns
module fan_holding_registers_tb
   import fan_regs_pkg::*;
;
   logic        clock = 0, nrst = 0, cold_start = 1, req_valid = 0, motor_running = 0;
   mb_req_t     req = '0;
   nv_word_t    restore = '0;
   logic [15:0] analog_level = 16'h0abc;
   logic [15:0] input_data, input_addr, got_data;
   logic        req_ready, input_read, fault_clear, got_nv, got_fc;
   mb_rsp_t     rsp;
   nv_word_t    nv_write;
   drive_cfg_t  cfg;
   logic [7:0]  got_exc;
   int          mismatches = 0, compares = 0, cycles = 0;
   always #25 clock = ~clock;
   fan_holding_registers u_fan_holding_registers (.clock(clock), .nrst(nrst),
      .cold_start(cold_start), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rsp(rsp), .input_read(input_read), .input_addr(input_addr), .input_data(input_data),
      .motor_running(motor_running), .restore(restore), .nv_write(nv_write),
      .fault_clear(fault_clear), .analog_level(analog_level), .cfg(cfg));
   fan_input_file u_fan_input_file (.clock(clock), .input_read(input_read),
      .input_addr(input_addr), .input_data(input_data));
   task automatic check(input logic [15:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic [7:0] f, input logic [15:0] a, d);
      @(negedge clock);
      req_valid = 1;
      req = '{f, a, d};
      @(negedge clock);
      req_valid = 0;
      for (int i = 0; i < 4 && !rsp.valid; i++) @(negedge clock);
      check({15'h0, rsp.valid}, 16'h1);
      got_exc = rsp.exc;
      got_data = rsp.data;
      got_nv = nv_write.valid;
      got_fc = fault_clear;
   endtask
   task automatic wr(input logic [15:0] a, d, input logic [7:0] e);
      xfer(8'h06, a, d);
      check({8'h0, got_exc}, {8'h0, e});
   endtask
   task automatic rd(input logic [15:0] a, exp);
      xfer(8'h03, a, 16'h0);
      check(got_data, exp);
   endtask
   task automatic do_reset(input logic cold);
      @(negedge clock);
      nrst = 0;
      cold_start = cold;
      repeat (5) @(negedge clock);
      nrst = 1;
   endtask
   task automatic t_access;
      rd(16'h0015, 16'h0);
      rd(16'h0020, 16'h4e20);
      rd(16'h0022, 16'h1);
      wr(16'h0042, 16'h04d2, 8'h0);
      xfer(8'h03, 16'h0042, 16'h0);
      check({8'h0, got_exc}, 16'h2);
      xfer(8'h10, 16'h0001, 16'h0);
      check({8'h0, got_exc}, 16'h1);
      xfer(8'h04, 16'h0003, 16'h0);
      check(got_data, 16'h5a03);
      wr(16'h0, 16'h1, 8'h0);
      check({15'h0, got_fc}, 16'h1);
      rd(16'h0, 16'h0);
      wr(16'h0, 16'h2, 8'h3);
      $display("test access done");
   endtask
   task automatic t_bounds;
      wr(16'h1, 16'd299, 8'h3);
      wr(16'h1, 16'd3000, 8'h0);
      wr(16'h2, 16'd2999, 8'h3);
      wr(16'h2, 16'd3001, 8'h3);
      wr(16'h15, 16'd2999, 8'h3);
      wr(16'h1, 16'd300, 8'h0);
      wr(16'h7, 16'd0, 8'h3);
      wr(16'h7, 16'd6501, 8'h3);
      wr(16'h7, 16'd1, 8'h0);
      wr(16'h7, 16'd1950, 8'h0);
      wr(16'h20, 16'd100, 8'h0);
      wr(16'h21, 16'd99, 8'h3);
      wr(16'h21, 16'd20001, 8'h3);
      wr(16'h22, 16'd13, 8'h3);
      wr(16'h1f, 16'd1, 8'h0);
      @(negedge clock);
      check({15'h0, cfg.feedback_invert}, 16'h1);
      check(cfg.current_limit, 16'd1950);
      check(cfg.skip_low, 16'd100);
      check(cfg.speed_floor, 16'd300);
      check(cfg.speed_ceiling, 16'd3000);
      $display("test bounds done");
   endtask
   task automatic t_modes;
      drive_family_t f;
      ref_source_t s;
      logic [15:0] r;
      wr(16'h32, 16'd100, 8'h0);
      for (int m = 0; m < 13; m++) begin
         f = m < 3 ? FAM_SPEED : m == 3 ? FAM_SLAVE : m < 7 ? FAM_AIRFLOW :
             m < 10 ? FAM_EMULATION : FAM_LOOP;
         s = m == 3 ? SRC_MASTER : m > 3 ? ref_source_t'((m - 4) % 3) :
             m == 0 ? SRC_TEMPORARY : m == 1 ? SRC_ANALOG : SRC_STORED;
         wr(16'h22, m[15:0], 8'h0);
         @(negedge clock);
         check({11'h0, cfg.family, cfg.source}, {11'h0, f, s});
         r = s == SRC_TEMPORARY ? 16'h04d2 : s == SRC_STORED ? 16'h0 : 16'h0abc;
         check(cfg.reference, m == 12 ? 16'd100 : r);
      end
      wr(16'h10, 16'd500, 8'h0);
      @(negedge clock);
      check(cfg.threshold_low, 16'h0);
      wr(16'h2e, 16'h3, 8'h0);
      @(negedge clock);
      check(cfg.threshold_low, 16'd500);
      $display("test modes done");
   endtask
   task automatic t_persist;
      motor_running = 1;
      wr(16'h24, 16'd2000, 8'h0);
      check({15'h0, got_nv}, 16'h0);
      motor_running = 0;
      wr(16'h24, 16'd2000, 8'h0);
      check({15'h0, got_nv}, 16'h1);
      wr(16'h42, 16'h04d2, 8'h0);
      check({15'h0, got_nv}, 16'h0);
      for (int c = 0; c < 3; c++) begin
         if (c > 0)
            do_reset(c == 2);
         wr(16'h22, 16'h0, 8'h0);
         @(negedge clock);
         check(cfg.reference, c == 2 ? 16'h0 : 16'h04d2);
         check(cfg.power_limit, c == 0 ? 16'd2000 : 16'd2650);
      end
      @(negedge clock);
      restore = '{1'b1, 16'h0023, 16'd1234};
      @(negedge clock);
      restore.valid = 0;
      rd(16'h0023, 16'd1234);
      $display("test persist done");
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         wrap_up;
      end
   end
   initial begin
      repeat (5) @(negedge clock);
      nrst = 1;
      t_access;
      t_bounds;
      t_modes;
      t_persist;
      wrap_up;
   end
endmodule
